// file: rtl/snsf_pkg.sv
// Constants, types and encodings shared by the serial memory front end
package snsf_pkg;

    // ==========================================================
    // Command op-codes, sent most significant bit first
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

    // ==========================================================
    // Status register field positions
    localparam int ST_LOCK_BIT = 7;
    localparam int ST_SPARE_HI = 6;
    localparam int ST_SPARE_LO = 4;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BUSY_BIT = 0;

    // Power-on values of the nonvolatile and volatile fields
    localparam logic ST_LOCK_RST = 1'h0;
    localparam logic [2:0] ST_SPARE_RST = 3'h0;
    localparam logic [1:0] ST_GUARD_RST = 2'h0;

    // ==========================================================
    // Array and write buffer geometry
    localparam int ADDR_W = 19;
    localparam int BUF_DEPTH = 256;
    localparam int HDR_BYTES = 4;
    localparam logic [8:0] BYTE_CNT_MAX = 9'h104;

    // ==========================================================
    // Internal write time and its cycle count at the 50 MHz clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_NS = 10000;
    localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Internal write sequencer
    typedef enum logic [1:0] {
        SNSF_IDLE,
        SNSF_DRAIN,
        SNSF_WAIT
    } snsf_state_t;

    // Link-side receive state, clocked on rising serial clock
    typedef struct packed {
        logic [2:0] cnt;
        logic [8:0] nbytes;
        logic [6:0] sh;
        logic [7:0] opcode;
        logic op_ok;
        logic [7:0] sr_data;
        logic sr_ok;
        logic [23:0] addr;
        logic [8:0] wcount;
    } snsf_rx_t;

    // Link-side transmit state, clocked on falling serial clock
    typedef struct packed {
        logic so;
        logic oe;
    } snsf_tx_t;

    // System-side state
    typedef struct packed {
        logic cs_m;
        logic cs_s;
        logic cs_d;
        logic wp_m;
        logic wp_s;
        logic lock;
        logic [2:0] spare;
        logic [1:0] guard;
        logic write_enable_latch;
        logic busy;
        snsf_state_t state;
        logic kind_array;
        logic [7:0] pend;
        logic [15:0] timer;
        logic [8:0] idx;
        logic [8:0] count;
        logic [18:0] base;
        logic we;
        logic [18:0] waddr;
        logic [7:0] wdata;
        logic [7:0] snap;
    } snsf_sys_t;

endpackage

// file: rtl/snsf_front.sv
// SPI slave front end, status register and write buffer of a serial memory
`timescale 1ns/1ps

// Operation
// - Deselected: standby, output off, inputs ignored
// - Pause low: output off, clock ignored
// - Sample input rising, drive output falling
// - Only clock modes 0 and 3
// - Input carries commands, output carries status
// - Bit 7 lock gates status writes with protect pin
// - Bits 6..4 volatile spare, writable and readable
// - Bits 3..2 block guard, writable and readable
// - Bit 1 latch: set and clear commands
// - Latch clears: reset, clear command, write end
// - Bit 0 busy during internal write
// - While busy only status read runs
// - Nineteen bit array address
// - Write buffer of 256 bytes
// - Op-codes 06, 04, 05, 01, 02, MSB first
// - Status read repeats while clocking continues
// - Status write ignores bits 1..0, starts at select rise
module snsf_front
    import snsf_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int BUF_BYTES = BUF_DEPTH
) (
    // System clock, reset and enable
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Serial link pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    // Status register view
    output logic [7:0] status_o,
    // Committed array write stream
    output logic arr_we_o,
    output logic [18:0] arr_addr_o,
    output logic [7:0] arr_data_o
);

    // ==========================================================
    // Elaboration checks
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 65535) begin : g_chk_wc
        $error("WRITE_CYCLES must lie in 1..65535");
    end
    if (BUF_BYTES != BUF_DEPTH) begin : g_chk_buf
        $error("BUF_BYTES must equal the buffer depth");
    end

    localparam logic [15:0] WAIT_LOAD = 16'(WRITE_CYCLES - 1);

    snsf_rx_t rx, next_rx;
    snsf_tx_t tx, next_tx;
    snsf_sys_t st, next_st;
    logic [7:0] wbuf [BUF_DEPTH];
    logic buf_we;
    logic [7:0] buf_idx;
    logic [7:0] buf_din;
    logic tx_off;
    logic reading;

    // ==========================================================
    // Receive side on the link clock
    // Frame fields restart when select rises; the decoded command,
    // status data and buffer count persist so the system side can take
    // them after the frame, when the serial clock has gone quiet.
    always_comb begin
        logic [7:0] b;
        b = {rx.sh, si_i};
        next_rx = rx;
        buf_we = 1'b0;
        buf_idx = rx.wcount[7:0];
        buf_din = b;
        if (hold_n_i) begin
            if (rx.cnt == 3'h0 && rx.nbytes == 9'h0) begin
                next_rx.op_ok = 1'b0;
                next_rx.sr_ok = 1'b0;
                next_rx.wcount = 9'h0;
            end
            next_rx.sh = b[6:0];
            next_rx.cnt = rx.cnt + 3'h1;
            if (rx.cnt == 3'h7) begin
                if (rx.nbytes != BYTE_CNT_MAX) begin
                    next_rx.nbytes = rx.nbytes + 9'h1;
                end
                if (rx.nbytes == 9'h0) begin
                    next_rx.opcode = b;
                    next_rx.op_ok = 1'b1;
                end else if (rx.opcode == OP_STATUS_WRITE && rx.nbytes == 9'h1) begin
                    next_rx.sr_data = b;
                    next_rx.sr_ok = 1'b1;
                end else if (rx.opcode == OP_ARRAY_WRITE) begin
                    if (rx.nbytes < 9'(HDR_BYTES)) begin
                        next_rx.addr = {rx.addr[15:0], b};
                    end else if (rx.wcount < 9'(BUF_DEPTH) && !st.snap[ST_BUSY_BIT]) begin
                        // Bytes past the buffer depth are dropped
                        buf_we = 1'b1;
                        next_rx.wcount = rx.wcount + 9'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rx.cnt <= 3'h0;
            rx.nbytes <= 9'h0;
            rx.sh <= 7'h0;
        end else begin
            rx <= next_rx;
        end
    end

    always_ff @(posedge sck_i) begin
        if (buf_we && !cs_n_i) begin
            wbuf[buf_idx] <= buf_din;
        end
    end

    // ==========================================================
    // Command freshness
    // The decoded op-code outlives its frame, so a select pulse without
    // any clock would replay it. The link side flips a token per op-code;
    // the system side absorbs the token while deselected and acts only
    // on one that arrived during the frame that just ended.
    logic op_tog;
    logic op_seen;
    logic op_fresh;

    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_tog <= 1'b0;
        end else if (!cs_n_i && hold_n_i && rx.cnt == 3'h7 && rx.nbytes == 9'h0) begin
            op_tog <= ~op_tog;
        end
    end

    assign op_fresh = op_tog ^ op_seen;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            op_seen <= 1'b0;
        end else if (ce_i && st.cs_s) begin
            op_seen <= op_tog;
        end
    end

    // ==========================================================
    // Transmit side on the falling link clock
    // Pause or deselect turns the driver off at once, not at an edge.
    assign tx_off = cs_n_i | ~hold_n_i;
    assign reading = rx.op_ok && rx.opcode == OP_STATUS_READ && rx.nbytes != 9'h0;

    always_comb begin
        next_tx.oe = reading;
        // Bit position wraps every byte, so the register repeats
        next_tx.so = reading ? st.snap[3'h7 - rx.cnt] : 1'b0;
    end

    always_ff @(negedge sck_i or posedge tx_off) begin
        if (tx_off) begin
            tx <= '0;
        end else begin
            tx <= next_tx;
        end
    end

    assign so_o = tx.so;
    assign so_oe_o = tx.oe;

    // ==========================================================
    // System side: command commit and internal write
    // Command fields from the link side are only read at the synchronised
    // select rise; the master has stopped the clock by then, so they are
    // stable. The status snapshot is refreshed only while deselected.
    always_comb begin
        logic rise;
        logic guarded;
        rise = st.cs_s & ~st.cs_d;
        guarded = st.lock & ~st.wp_s;
        next_st = st;
        next_st.cs_m = cs_n_i;
        next_st.cs_s = st.cs_m;
        next_st.cs_d = st.cs_s;
        next_st.wp_m = wp_n_i;
        next_st.wp_s = st.wp_m;
        next_st.we = 1'b0;
        if (st.cs_s) begin
            next_st.snap = {st.lock, st.spare, st.guard, st.write_enable_latch, st.busy};
        end
        case (st.state)
            SNSF_IDLE: begin
                if (rise && rx.op_ok && op_fresh && !st.busy) begin
                    case (rx.opcode)
                        OP_SET_LATCH: next_st.write_enable_latch = 1'b1;
                        OP_CLEAR_LATCH: next_st.write_enable_latch = 1'b0;
                        OP_STATUS_WRITE: begin
                            if (st.write_enable_latch && rx.sr_ok && !guarded) begin
                                next_st.pend = rx.sr_data;
                                next_st.busy = 1'b1;
                                next_st.kind_array = 1'b0;
                                next_st.timer = WAIT_LOAD;
                                next_st.state = SNSF_WAIT;
                            end
                        end
                        OP_ARRAY_WRITE: begin
                            if (st.write_enable_latch && rx.wcount != 9'h0) begin
                                next_st.busy = 1'b1;
                                next_st.kind_array = 1'b1;
                                next_st.idx = 9'h0;
                                next_st.count = rx.wcount;
                                next_st.base = rx.addr[18:0];
                                next_st.state = SNSF_DRAIN;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            SNSF_DRAIN: begin
                next_st.we = 1'b1;
                next_st.waddr = st.base + 19'(st.idx);
                next_st.wdata = wbuf[st.idx[7:0]];
                next_st.idx = st.idx + 9'h1;
                if (st.idx == st.count - 9'h1) begin
                    next_st.timer = WAIT_LOAD;
                    next_st.state = SNSF_WAIT;
                end
            end
            SNSF_WAIT: begin
                next_st.timer = st.timer - 16'h1;
                if (st.timer == 16'h0) begin
                    next_st.busy = 1'b0;
                    next_st.write_enable_latch = 1'b0;
                    if (!st.kind_array) begin
                        // Latch and busy positions of the written byte are ignored
                        next_st.lock = st.pend[ST_LOCK_BIT];
                        next_st.spare = st.pend[ST_SPARE_HI:ST_SPARE_LO];
                        next_st.guard = st.pend[ST_GUARD_HI:ST_GUARD_LO];
                    end
                    next_st.state = SNSF_IDLE;
                end
            end
            default: next_st.state = SNSF_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.cs_m <= 1'b1;
            st.cs_s <= 1'b1;
            st.cs_d <= 1'b1;
            st.wp_m <= 1'b1;
            st.wp_s <= 1'b1;
            st.lock <= ST_LOCK_RST;
            st.spare <= ST_SPARE_RST;
            st.guard <= ST_GUARD_RST;
            st.write_enable_latch <= 1'b0;
            st.state <= SNSF_IDLE;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign status_o = {st.lock, st.spare, st.guard, st.write_enable_latch, st.busy};
    assign arr_we_o = st.we;
    assign arr_addr_o = st.waddr;
    assign arr_data_o = st.wdata;

    // ==========================================================
    // Assertions
    logic a_rise;
    logic a_open;
    assign a_rise = st.cs_s & ~st.cs_d & ce_i;
    assign a_open = a_rise && rx.op_ok && op_fresh && !st.busy && st.state == SNSF_IDLE;

    a_standby_hiz: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cs_n_i |-> !so_oe_o) else $error("output driven while deselected");
    a_pause_hiz: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !hold_n_i |-> !so_oe_o) else $error("output driven during pause");
    a_pause_hold: assert property (@(posedge sck_i) disable iff (cs_n_i)
        !hold_n_i |=> rx.cnt == $past(rx.cnt)) else $error("bit count moved in pause");
    a_latch_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_open && rx.opcode == OP_SET_LATCH |=> st.write_enable_latch) else $error("latch not set");
    a_latch_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_open && rx.opcode == OP_CLEAR_LATCH |=> !st.write_enable_latch) else $error("latch not cleared");
    a_busy_ignore: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_rise && st.busy && !st.write_enable_latch |=> !st.write_enable_latch) else $error("command ran while busy");
    a_lock_guard: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_open && rx.opcode == OP_STATUS_WRITE && st.lock && !st.wp_s |=> !st.busy)
        else $error("status write passed the lock");
    a_status_write_cmd_start: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_open && rx.opcode == OP_STATUS_WRITE && st.write_enable_latch && rx.sr_ok && !(st.lock && !st.wp_s)
        |=> st.busy && st.state == SNSF_WAIT) else $error("status write did not start");
    a_done_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(st.busy) |-> !st.write_enable_latch && st.state == SNSF_IDLE) else $error("latch kept at write end");
    a_status_write_cmd_apply: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && st.state == SNSF_WAIT && st.timer == 16'h0 && !st.kind_array
        |=> st.spare == $past(st.pend[6:4]) && st.guard == $past(st.pend[3:2])
        && st.lock == $past(st.pend[7])) else $error("status bits not applied");
    a_drain_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st.we && $past(st.we) |-> st.waddr == 19'($past(st.waddr) + 19'h1))
        else $error("array address did not step");
    a_busy_state: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st.state != SNSF_IDLE |-> st.busy) else $error("sequencer active without busy");
    a_fields_keep: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(st.state == SNSF_WAIT && st.timer == 16'h0)
        |=> $stable(st.guard) && $stable(st.lock) && $stable(st.spare))
        else $error("status fields changed outside a write");
    a_wel_keep: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st.state == SNSF_WAIT && st.timer != 16'h0 |=> $stable(st.write_enable_latch))
        else $error("latch moved during a write");
    a_drain_limit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st.state == SNSF_DRAIN |-> st.idx < 9'(BUF_BYTES)) else $error("drain past buffer");
    a_replay_block: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_rise && !op_fresh && st.state == SNSF_IDLE |=> $stable(st.write_enable_latch))
        else $error("stale command replayed");
    a_out_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        so_oe_o |-> !cs_n_i && hold_n_i) else $error("output driven outside a frame");

    c_status_write: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_open && rx.opcode == OP_STATUS_WRITE ##1 st.busy);
    c_array_drain: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st.state == SNSF_DRAIN ##1 st.state == SNSF_WAIT);
    c_busy_poll: cover property (@(negedge sck_i) disable iff (cs_n_i)
        tx.oe && st.snap[ST_BUSY_BIT]);
    c_pause_mid: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !hold_n_i && !cs_n_i);
    c_lock_refuse: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        a_open && rx.opcode == OP_STATUS_WRITE && st.lock && !st.wp_s);

endmodule

// file: bench/snsf_spi_master.sv
// Host SPI master model that drives the serial memory link
`timescale 1ns/1ps

module snsf_spi_master (
    // Serial link pins
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    localparam int HALF_NS = 32;

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end

    // ==========================================================
    // One frame: n_hdr header bytes, then n_dat bytes counting up from 0
    task automatic frame(input logic m3, input logic [31:0] hdr, input int n_hdr,
                         input int n_dat, input int hold_bit,
                         output logic [7:0] rx, output logic oe_held);
        logic [7:0] b;
        oe_held = 1'b0;
        rx = 8'h00;
        sck_o = m3;
        #103;
        cs_n_o = 1'b0;
        #100;
        for (int i = 0; i < (n_hdr + n_dat) * 8; i++) begin
            if (i == hold_bit) begin
                // Clock pulses during the pause must be disregarded
                hold_n_o = 1'b0;
                #HALF_NS;
                sck_o = ~sck_o;
                #HALF_NS;
                oe_held = so_oe_i;
                sck_o = ~sck_o;
                #HALF_NS;
                hold_n_o = 1'b1;
                #HALF_NS;
            end
            if (i < n_hdr * 8) begin
                b = hdr[8 * (n_hdr - 1 - i / 8) +: 8];
            end else begin
                b = 8'((i / 8) - n_hdr);
            end
            sck_o = 1'b0;
            si_o = b[7 - i % 8];
            #HALF_NS;
            sck_o = 1'b1;
            rx = {rx[6:0], so_i};
            #HALF_NS;
        end
        if (!m3) begin
            sck_o = 1'b0;
        end
        #HALF_NS;
        cs_n_o = 1'b1;
        // Released data line shows no stale level
        si_o = ~si_o;
        #200;
    endtask
endmodule

// file: bench/tb_top.sv
// Self-checking testbench of the serial memory front end
`timescale 1ns/1ps

module tb_top;
    import snsf_pkg::*;

    // Long enough that a second frame lands inside the internal write
    localparam int WCYC = 200;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wp_n_i = 1'b1;
    logic ce = 1'b1;
    logic sck, cs_n, si, hold_n, so_o, so_oe_o, arr_we_o, oe_held;
    logic [7:0] status_o, arr_data_o, rx;
    logic [18:0] arr_addr_o;
    logic [26:0] wlog [0:299];
    int errors = 0;
    int num_checks = 0;
    int we_cnt = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    snsf_front #(.WRITE_CYCLES(WCYC), .BUF_BYTES(BUF_DEPTH)) dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i),
        .so_o(so_o), .so_oe_o(so_oe_o), .status_o(status_o),
        .arr_we_o(arr_we_o), .arr_addr_o(arr_addr_o), .arr_data_o(arr_data_o)
    );

    snsf_spi_master host (
        .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
        .so_i(so_o), .so_oe_i(so_oe_o)
    );

    always @(posedge ref_clk_i) begin
        if (arr_we_o === 1'b1) begin
            wlog[we_cnt] <= {arr_addr_o, arr_data_o};
            we_cnt <= we_cnt + 1;
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [26:0] seen, input logic [26:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic [31:0] hdr, input int n);
        host.frame(1'b0, hdr, n, 0, -1, rx, oe_held);
    endtask

    task automatic wait_idle();
        int n = 0;
        while (status_o[0] !== 1'b0 && n < 2000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            final_report();
        end
        repeat (2) @(posedge ref_clk_i);
    endtask

    // ==========================================================
    // Scenarios
    task automatic ce_freeze();
        @(posedge ref_clk_i);
        ce <= 1'b0;
        cmd(32'(OP_SET_LATCH), 1);
        check("status frozen with enable low", status_o, 8'h00);
        @(posedge ref_clk_i);
        ce <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        check("frame lost while frozen", status_o, 8'h00);
    endtask

    task automatic latch_rw();
        cmd(32'(OP_SET_LATCH), 1);
        check("latch set", status_o, 8'h02);
        host.frame(1'b0, 32'(OP_STATUS_READ), 1, 1, -1, rx, oe_held);
        check("status read mode 0", rx, 8'h02);
        host.frame(1'b1, 32'(OP_STATUS_READ), 1, 2, 19, rx, oe_held);
        check("status read mode 3 repeated", rx, 8'h02);
        check("output enable in pause", oe_held, 1'b0);
        check("output enable deselected", so_oe_o, 1'b0);
        cmd(32'(OP_CLEAR_LATCH), 1);
        check("latch cleared", status_o, 8'h00);
    endtask

    task automatic status_wr();
        cmd({16'h0, OP_STATUS_WRITE, 8'hFF}, 2);
        check("status write without latch", status_o, 8'h00);
        cmd(32'(OP_SET_LATCH), 1);
        cmd({16'h0, OP_STATUS_WRITE, 8'hFF}, 2);
        check("busy after status write", status_o, 8'h03);
        cmd(32'(OP_CLEAR_LATCH), 1);
        check("command ignored while busy", status_o, 8'h03);
        host.frame(1'b0, 32'(OP_STATUS_READ), 1, 1, -1, rx, oe_held);
        check("status read while busy", rx, 8'h03);
        wait_idle();
        check("status after write", status_o, 8'hFC);
    endtask

    task automatic lock_guard();
        @(posedge ref_clk_i);
        wp_n_i <= 1'b0;
        cmd(32'(OP_SET_LATCH), 1);
        cmd({16'h0, OP_STATUS_WRITE, 8'h00}, 2);
        check("locked status write", status_o, 8'hFE);
        @(posedge ref_clk_i);
        wp_n_i <= 1'b1;
        cmd({16'h0, OP_STATUS_WRITE, 8'h00}, 2);
        wait_idle();
        check("unlocked status write", status_o, 8'h00);
    endtask

    task automatic array_wr();
        cmd(32'(OP_SET_LATCH), 1);
        // Address at the top of the array, two bytes more than the buffer
        host.frame(1'b0, {OP_ARRAY_WRITE, 24'h07FFFF}, 4, 258, -1, rx, oe_held);
        wait_idle();
        check("committed byte count", 27'(we_cnt), 27'd256);
        check("first byte", wlog[0], {19'h7FFFF, 8'h00});
        check("wrapped byte", wlog[1], {19'h00000, 8'h01});
        check("last byte", wlog[255], {19'h000FE, 8'hFF});
        check("latch after array write", status_o, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        check("status after reset", status_o, 8'h00);
        check("output enable idle", so_oe_o, 1'b0);
        ce_freeze();
        latch_rw();
        status_wr();
        lock_guard();
        array_wr();
        final_report();
    end
endmodule
